// file: core/tsa_core.sv
// two-wire unit status, bus error and arbitration core with apb slave
// ==========================================================================
// What this block does
// - stop or restart while selected gives A0
// - after A0 clear, unselected target, ack gates matching
// - begin_flag at A0 clear takes bus ownership when bus free, no start driven on the lines
// - status F8 whenever op_done_flag clear
// - start or stop mid frame gives 00
// - bus error sets op_done_flag
// - recovery: unselected, clear halt, release lines
// - restart keeps bus ownership for direction change
// - driving one but seeing zero loses arbitration
// - identical traffic never flags arbitration loss
// - data or direction loss: unselected or restart
// - address loss: check selection, enter target mode
// - unselected address loser: unselected or restart
// - op_done_flag set holds clock low, except after a bus error (code 00)
// - status code in bits 7:3, prescaler low
// - address bit 0 enables general call
`include "tsa_defines.svh"
module tsa_core
(
  input  wire logic        pclk,         // system clock 100 mhz
  input  wire logic        presetn,      // async reset, active low
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb access phase
  input  wire logic        pwrite,       // apb direction
  input  wire logic [11:0] paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error, unmapped address
  input  wire logic        scl_in,       // clock line level
  input  wire logic        sda_in,       // data line level
  output logic             scl_oe,       // drive clock low
  output logic             sda_oe,       // drive data low
  output logic             scl_out,      // clock output value, always low
  output logic             sda_out,      // data output value, always low
  output logic             irq           // level interrupt
);
  // ========================================================================
  // line synchronisers and edge detection
  logic [1:0] scl_sync_q;    // clock two-flop synchroniser
  logic [1:0] sda_sync_q;    // data two-flop synchroniser
  logic       scl_prev_q;    // previous clock level
  logic       sda_prev_q;    // previous data level
  tsa_pkg::tsa_line_s line;  // decoded line events
  // synchronise both lines before any logic reads them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end
  assign line.scl      = scl_sync_q[1];
  assign line.sda      = sda_sync_q[1];
  assign line.scl_rise = line.scl & ~scl_prev_q;
  assign line.start    = line.scl & scl_prev_q & sda_prev_q & ~line.sda;
  assign line.stop     = line.scl & scl_prev_q & ~sda_prev_q & line.sda;
  // ========================================================================
  // registers
  logic       done_q;        // op_done_flag
  logic       ack_q;         // ack_enable
  logic       begin_q;       // begin_flag
  logic       halt_q;        // halt_flag
  logic       en_q;          // unit enable
  logic [7:0] code_q;        // latched condition code
  logic [1:0] presc_q;       // prescaler bits
  logic [7:0] addr_q;        // own_node_address and general_call_enable
  logic [7:0] data_q;        // data_reg, byte shifted in at the last event
  logic [2:0] irq_stat_q;    // sticky events
  logic [2:0] irq_mask_q;    // event enables
  // apb decode
  wire        wr_en    = psel & penable & pwrite;
  wire        hit_ctrl = (paddr == `TSA_OFS_CTRL);
  wire        hit_stat = (paddr == `TSA_OFS_STATUS);
  wire        hit_addr = (paddr == `TSA_OFS_ADDR);
  wire        hit_data = (paddr == `TSA_OFS_DATA);
  wire        hit_is   = (paddr == `TSA_OFS_IRQ_STAT);
  wire        hit_im   = (paddr == `TSA_OFS_IRQ_MASK);
  wire        mapped   = hit_ctrl | hit_stat | hit_addr | hit_data | hit_is | hit_im;
  wire        wr_ctrl  = wr_en & hit_ctrl;
  wire        done_clr = wr_ctrl & pwdata[`TSA_CTL_DONE];
  wire        recover  = done_clr & pwdata[`TSA_CTL_HALT] & (code_q == `TSA_ST_BUSERR);
  // ========================================================================
  // frame tracking and arbitration
  tsa_pkg::tsa_frame_e frame_q;  // frame position
  logic [3:0] bit_q;             // bits seen in current byte
  logic [7:0] shift_q;           // bits shifted in
  logic       selected_q;        // addressed as target
  logic       owner_q;           // we own the bus as controller
  logic       busy_q;            // bus busy between start and stop
  logic       recog_q;           // address recognition active
  logic       pend_start_q;      // start wanted once bus free
  logic       drive_one_q;       // we release sda for a one
  // set events from the bus
  wire        in_frame   = (frame_q == tsa_pkg::FR_ADDR) | (frame_q == tsa_pkg::FR_DATA)
                         | (frame_q == tsa_pkg::FR_ACK);
  // stop or restart is legal only in the high phase of a byte's first bit
  wire        bus_err    = en_q & in_frame & (bit_q != 4'd1) & (line.start | line.stop);
  wire        stop_sel   = en_q & selected_q & (line.start | line.stop) & ~bus_err;
  wire        arb_lost   = owner_q & drive_one_q & line.scl_rise & ~line.sda;
  wire        addr_done  = (frame_q == tsa_pkg::FR_ADDR) & line.scl_rise & (bit_q == 4'd7);
  wire [7:0]  addr_byte  = {shift_q[6:0], line.sda};
  wire        own_match  = recog_q & ack_q & (addr_byte[7:1] == addr_q[7:1]);
  wire        gc_match   = recog_q & ack_q & addr_q[0] & (addr_byte[7:1] == 7'h00);
  wire        any_event  = bus_err | stop_sel | arb_lost | (addr_done & (own_match | gc_match));
  // next status code, priority: bus error, stop while selected, arbitration
  function automatic logic [7:0] arb_code(input logic own, input logic gc, input logic rd);
    if (own & rd)
      arb_code = `TSA_ST_ARB_ST;
    else if (own)
      arb_code = `TSA_ST_ARB_SR;
    else if (gc)
      arb_code = `TSA_ST_ARB_GC;
    else
      arb_code = `TSA_ST_ARB_LOST;
  endfunction
  logic [7:0] code_d;
  always_comb
  begin
    code_d = code_q;
    if (bus_err)
      code_d = `TSA_ST_BUSERR;
    else if (stop_sel)
      code_d = `TSA_ST_STOP_SEL;
    else if (arb_lost)
      code_d = `TSA_ST_ARB_LOST;
    else if (addr_done & (own_match | gc_match))
      code_d = owner_q ? arb_code(own_match, gc_match & ~own_match, addr_byte[0])
             : (addr_byte[0] ? `TSA_ST_ST_ADDR : (own_match ? `TSA_ST_SR_ADDR
             : `TSA_ST_GC_ADDR));
  end
  // frame position tracker
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_q <= tsa_pkg::FR_IDLE;
      bit_q   <= 4'd0;
      shift_q <= 8'h00;
      busy_q  <= 1'b0;
    end
    else if (line.start)
    begin
      frame_q <= tsa_pkg::FR_ADDR;
      bit_q   <= 4'd0;
      busy_q  <= 1'b1;
    end
    else if (line.stop | bus_err)
    begin
      frame_q <= tsa_pkg::FR_IDLE;
      bit_q   <= 4'd0;
      busy_q  <= 1'b0;
    end
    else if (line.scl_rise)
    begin
      case (frame_q)
        tsa_pkg::FR_ADDR, tsa_pkg::FR_DATA:
        begin
          shift_q <= {shift_q[6:0], line.sda};
          bit_q   <= (bit_q == 4'd7) ? 4'd0 : bit_q + 4'd1;
          if (bit_q == 4'd7)
            frame_q <= tsa_pkg::FR_ACK;
        end
        tsa_pkg::FR_ACK:
          frame_q <= tsa_pkg::FR_DATA;
        default:
          frame_q <= frame_q;
      endcase
    end
  end
  // ownership, selection and pending start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      selected_q   <= 1'b0;
      owner_q      <= 1'b0;
      recog_q      <= 1'b0;
      pend_start_q <= 1'b0;
      drive_one_q  <= 1'b0;
    end
    else
    begin
      if (bus_err | stop_sel | arb_lost)
        owner_q <= 1'b0;
      else if (pend_start_q & ~busy_q)
        owner_q <= 1'b1;
      drive_one_q <= owner_q & line.sda;
      if (bus_err | stop_sel)
        selected_q <= 1'b0;
      else if (addr_done & (own_match | gc_match))
        selected_q <= 1'b1;
      if (done_clr & (code_q == `TSA_ST_STOP_SEL) | recover)
        recog_q <= 1'b1;
      else if (~en_q)
        recog_q <= 1'b0;
      if (done_clr & pwdata[`TSA_CTL_BEGIN] & ~pwdata[`TSA_CTL_HALT])
        pend_start_q <= 1'b1;
      else if (owner_q)
        pend_start_q <= 1'b0;
    end
  end
  // control bits, op_done set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_q  <= 1'b0;
      ack_q   <= 1'b0;
      begin_q <= 1'b0;
      halt_q  <= 1'b0;
      en_q    <= 1'b0;
      code_q  <= `TSA_ST_IDLE;
    end
    else
    begin
      if (any_event)
      begin
        done_q <= 1'b1;
        code_q <= code_d;
      end
      else if (done_clr)
        done_q <= 1'b0;
      if (recover)
        halt_q <= 1'b0;
      else if (wr_ctrl)
        halt_q <= pwdata[`TSA_CTL_HALT];
      if (wr_ctrl)
      begin
        ack_q   <= pwdata[`TSA_CTL_ACK];
        begin_q <= pwdata[`TSA_CTL_BEGIN];
        en_q    <= pwdata[`TSA_CTL_EN];
      end
    end
  end
  // other software registers and sticky interrupts
  wire [2:0] irq_set = {arb_lost, bus_err, any_event};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_q    <= 2'b00;
      addr_q     <= `TSA_RST_ADDR;
      data_q     <= `TSA_RST_DATA;
      irq_stat_q <= 3'b000;
      irq_mask_q <= 3'b000;
    end
    else
    begin
      if (wr_en & hit_stat)
        presc_q <= pwdata[1:0];
      if (wr_en & hit_addr)
        addr_q <= pwdata[7:0];
      if (any_event)
        data_q <= addr_byte;
      else if (wr_en & hit_data & done_q)
        data_q <= pwdata[7:0];
      irq_stat_q <= irq_set | (irq_stat_q & ~((wr_en & hit_is) ? pwdata[2:0] : 3'b000));
      if (wr_en & hit_im)
        irq_mask_q <= pwdata[2:0];
    end
  end
  // ========================================================================
  // read mux, status shows idle while flag clear
  wire [7:0] code_vis = done_q ? code_q : `TSA_ST_IDLE;
  wire [7:0] stat_rd  = {code_vis[7:3], 1'b0, presc_q};
  wire [7:0] ctrl_rd  = {done_q, ack_q, begin_q, halt_q, 1'b0, en_q, 2'b00};
  wire [31:0] rd_d    = hit_ctrl ? {24'h00_0000, ctrl_rd}
                      : hit_stat ? {24'h00_0000, stat_rd}
                      : hit_addr ? {24'h00_0000, addr_q}
                      : hit_data ? {24'h00_0000, data_q}
                      : hit_is   ? {29'h0, irq_stat_q}
                      : hit_im   ? {29'h0, irq_mask_q} : 32'h0000_0000;
  // registered apb answer, no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      prdata  <= rd_d;
      pslverr <= psel & ~penable & ~mapped;
    end
  end
  // line drivers, irq
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      irq     <= 1'b0;
    end
    else
    begin
      scl_oe  <= en_q & done_q & ~line.scl & (code_q != `TSA_ST_BUSERR);
      sda_oe  <= 1'b0;
      irq     <= |(irq_stat_q & irq_mask_q);
    end
  end
  // ========================================================================
  // checks
  a_idle_code: assert property (@(posedge pclk) disable iff (!presetn)
    !done_q |-> stat_rd[7:3] == 5'h1F) else $error("idle code wrong");
  a_buserr_flag: assert property (@(posedge pclk) disable iff (!presetn)
    bus_err |=> done_q && code_q == 8'h00) else $error("bus error not flagged");
  a_stop_sel: assert property (@(posedge pclk) disable iff (!presetn)
    stop_sel |=> done_q && code_q == 8'hA0) else $error("stop code wrong");
  a_arb_owner: assert property (@(posedge pclk) disable iff (!presetn)
    arb_lost |=> !owner_q) else $error("owner kept after loss");
  a_recover_halt: assert property (@(posedge pclk) disable iff (!presetn)
    recover && !any_event |=> !halt_q && !done_q)
    else $error("recovery failed");
  a_sda_free: assert property (@(posedge pclk) disable iff (!presetn)
    !sda_oe) else $error("sda driven");
  a_stretch: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(scl_oe) |-> $past(done_q)) else $error("stretch without flag");
  a_no_arb_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !owner_q |-> !arb_lost) else $error("loss without owner");
  c_buserr: cover property (@(posedge pclk) disable iff (!presetn) bus_err);
  c_stop_sel: cover property (@(posedge pclk) disable iff (!presetn) stop_sel);
  c_arb: cover property (@(posedge pclk) disable iff (!presetn) arb_lost);
endmodule

// file: core/tsa_defines.svh
// constants for the two-wire status, error and arbitration block
`ifndef TSA_DEFINES_SVH
`define TSA_DEFINES_SVH
// register byte offsets
`define TSA_OFS_CTRL      12'h000
`define TSA_OFS_STATUS    12'h004
`define TSA_OFS_ADDR      12'h008
`define TSA_OFS_DATA      12'h00C
`define TSA_OFS_IRQ_STAT  12'h010
`define TSA_OFS_IRQ_MASK  12'h014
// control field positions
`define TSA_CTL_DONE      7
`define TSA_CTL_ACK       6
`define TSA_CTL_BEGIN     5
`define TSA_CTL_HALT      4
`define TSA_CTL_EN        2
// status codes, bits 7:3
`define TSA_ST_IDLE       8'hF8
`define TSA_ST_BUSERR     8'h00
`define TSA_ST_STOP_SEL   8'hA0
`define TSA_ST_START      8'h08
`define TSA_ST_RSTART     8'h10
`define TSA_ST_ARB_LOST   8'h38
`define TSA_ST_ARB_SR     8'h68
`define TSA_ST_ARB_GC     8'h78
`define TSA_ST_ARB_ST     8'hB0
`define TSA_ST_SR_ADDR    8'h60
`define TSA_ST_GC_ADDR    8'h70
`define TSA_ST_ST_ADDR    8'hA8
// reset values
`define TSA_RST_ADDR      8'hFE
`define TSA_RST_DATA      8'hFF
// irq bit positions
`define TSA_IRQ_DONE      0
`define TSA_IRQ_BUSERR    1
`define TSA_IRQ_ARB       2
`endif

// file: core/tsa_pkg.sv
// types for the two-wire status, error and arbitration block
package tsa_pkg;
  // bus-side frame tracker states
  typedef enum logic [4:0]
  {
    FR_IDLE = 5'b00001,  // bus free or not involved
    FR_ADDR = 5'b00010,  // shifting an address byte
    FR_DATA = 5'b00100,  // shifting a data byte
    FR_ACK  = 5'b01000,  // acknowledge bit slot
    FR_HOLD = 5'b10000   // waiting on software
  } tsa_frame_e;
  // synchronised and edge-detected line view
  typedef struct packed
  {
    logic scl;       // synchronised clock level
    logic sda;       // synchronised data level
    logic scl_rise;  // clock rising edge
    logic start;     // start or repeated start seen
    logic stop;      // stop seen
  } tsa_line_s;
endpackage

// file: bench/tsa_peer.sv
// behavioural two-wire controller on the far side of the lines
module tsa_peer
(
  input  wire logic scl,     // clock wire level
  input  wire logic sda,     // data wire level
  output logic      scl_lo,  // pull clock low
  output logic      sda_lo   // pull data low
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 40;  // half of the 80 ns link period
  // lines released at time zero, clock stands still
  initial
  begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  // ==========================================================
  // line conditions
  // one clock pulse, waits out a stretch by the device
  task automatic pulse();
    #HALF scl_lo = 1'b0;
    wait (scl === 1'b1);
    #HALF scl_lo = 1'b1;
  endtask
  // start: data falls while clock high
  task automatic start();
    sda_lo = 1'b0;
    #HALF scl_lo = 1'b0;
    wait (scl === 1'b1);
    #HALF sda_lo = 1'b1;
    #HALF scl_lo = 1'b1;
  endtask
  // stop: data rises while clock high, then both released
  task automatic stop();
    sda_lo = 1'b1;
    #HALF scl_lo = 1'b0;
    wait (scl === 1'b1);
    #HALF sda_lo = 1'b0;
    #HALF;
  endtask
  // msb first, data changes only while clock low
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      sda_lo = !b[7 - i];
      pulse();
    end
  endtask
  // whole byte plus a released acknowledge slot
  task automatic send_byte(input logic [7:0] b);
    send_bits(b, 8);
    sda_lo = 1'b0;
    pulse();
  endtask
endmodule

// file: bench/tb_tsa_core.sv
// self-checking bench for the status, bus error and arbitration core
`include "tsa_defines.svh"
module tb_tsa_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk;        // system clock
  logic        presetn;     // reset, active low
  logic        psel;        // apb select
  logic        penable;     // apb access
  logic        pwrite;      // apb direction
  logic [11:0] paddr;       // apb address
  logic [31:0] pwdata;      // apb write data
  logic [31:0] prdata;      // apb read data
  logic        pready;      // apb ready
  logic        pslverr;     // apb error
  logic        scl_oe;      // device pulls clock
  logic        sda_oe;      // device pulls data
  logic        scl_out;     // device clock value
  logic        sda_out;     // device data value
  logic        irq;         // interrupt
  logic        p_scl_lo;    // peer pulls clock
  logic        p_sda_lo;    // peer pulls data
  logic        scl_w;       // resolved clock wire
  logic        sda_w;       // resolved data wire
  logic [31:0] rd;          // last read word
  logic        err;         // last slave error
  int          n_mismatch;  // mismatches
  int          checks;      // comparisons
  int          cyc;         // cycles run
  // pull-ups: a line is low only while someone pulls it
  assign scl_w = !((scl_oe && !scl_out) || p_scl_lo);
  assign sda_w = !((sda_oe && !sda_out) || p_sda_lo);
  tsa_core i_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_w), .sda_in(sda_w),
    .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_out(scl_out),
    .sda_out(sda_out), .irq(irq)
  );
  tsa_peer i_peer (.scl(scl_w), .sda(sda_w), .scl_lo(p_scl_lo), .sda_lo(p_sda_lo));
  // 100 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ==========================================================
  // shared tasks
  // verdict and end of run
  task automatic summarize();
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // read a register and compare
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // poll control until op_done_flag is up, no bound of its own
  task automatic wait_done();
    do
    begin
      apb(1'b0, `TSA_OFS_CTRL, 32'h0000_0000);
    end
    while (rd[7] !== 1'b1);
  endtask
  // ==========================================================
  // scenarios
  // reset values, prescaler bits, unmapped address
  task automatic t_reset();
    rdchk(`TSA_OFS_CTRL, 32'h0000_0000);
    rdchk(`TSA_OFS_STATUS, 32'h0000_00f8);
    rdchk(`TSA_OFS_ADDR, 32'h0000_00fe);
    rdchk(`TSA_OFS_DATA, 32'h0000_00ff);
    apb(1'b1, `TSA_OFS_STATUS, 32'h0000_0003);
    rdchk(`TSA_OFS_STATUS, 32'h0000_00fb);
    apb(1'b1, `TSA_OFS_STATUS, 32'h0000_0000);
    apb(1'b0, 12'h0fc, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
  endtask
  // stop in mid byte, interrupt masking, recovery
  task automatic t_buserr();
    apb(1'b1, `TSA_OFS_IRQ_MASK, 32'h0000_0002);
    apb(1'b1, `TSA_OFS_CTRL, 32'h0000_0044);
    i_peer.start();
    i_peer.send_bits(8'ha5, 3);
    i_peer.stop();
    wait_done();
    chk(rd, 32'h0000_00c4);
    rdchk(`TSA_OFS_STATUS, 32'h0000_0000);
    chk({31'h0, scl_w}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    rdchk(`TSA_OFS_IRQ_STAT, 32'h0000_0003);
    apb(1'b1, `TSA_OFS_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `TSA_OFS_CTRL, 32'h0000_00d4);
    rdchk(`TSA_OFS_CTRL, 32'h0000_0044);
    rdchk(`TSA_OFS_STATUS, 32'h0000_00f8);
    chk({31'h0, scl_w}, 32'h0000_0001);
    apb(1'b1, `TSA_OFS_IRQ_STAT, 32'h0000_0007);
    rdchk(`TSA_OFS_IRQ_STAT, 32'h0000_0000);
  endtask
  // selected, then stop; then ack off ignores own address
  task automatic t_selstop();
    apb(1'b1, `TSA_OFS_ADDR, 32'h0000_0054);
    apb(1'b1, `TSA_OFS_CTRL, 32'h0000_0044);
    i_peer.start();
    fork
      i_peer.send_byte(8'h54);
      begin
        wait_done();
        repeat (10) @(posedge pclk);
        chk({31'h0, scl_w}, 32'h0000_0000);
        rdchk(`TSA_OFS_STATUS, {24'h00_0000, `TSA_ST_SR_ADDR});
        rdchk(`TSA_OFS_DATA, 32'h0000_0054);
        apb(1'b1, `TSA_OFS_CTRL, 32'h0000_00c4);
      end
    join
    i_peer.stop();
    wait_done();
    rdchk(`TSA_OFS_STATUS, 32'h0000_00a0);
    apb(1'b1, `TSA_OFS_CTRL, 32'h0000_0084);
    rdchk(`TSA_OFS_STATUS, 32'h0000_00f8);
    i_peer.start();
    i_peer.send_byte(8'h54);
    i_peer.stop();
    repeat (20) @(posedge pclk);
    rdchk(`TSA_OFS_CTRL, 32'h0000_0004);
    rdchk(`TSA_OFS_STATUS, 32'h0000_00f8);
    // general call recognised once bit 0 of the address is set
    apb(1'b1, `TSA_OFS_ADDR, 32'h0000_0055);
    apb(1'b1, `TSA_OFS_CTRL, 32'h0000_0044);
    i_peer.start();
    fork
      i_peer.send_byte(8'h00);
      begin
        wait_done();
        rdchk(`TSA_OFS_STATUS, {24'h00_0000, `TSA_ST_GC_ADDR});
        apb(1'b1, `TSA_OFS_CTRL, 32'h0000_00c4);
      end
    join
    i_peer.stop();
    wait_done();
    rdchk(`TSA_OFS_STATUS, 32'h0000_00a0);
    apb(1'b1, `TSA_OFS_CTRL, 32'h0000_0084);
  endtask
  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  // main sequence
  initial
  begin
    n_mismatch = 0;
    checks     = 0;
    cyc        = 0;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_buserr();
    t_selstop();
    summarize();
  end
endmodule
